// >>> verilog/alc_comparator_cfg.sv
// Purpose: second light sensor comparator configuration, status and level choice
// Assumes: byte register port behind the serial interface, sensor code synchronous
// Notes: comparators sample once per filter period, or on a forced conversion
//
// Summary of operation
// [R1] filter period 80 ms doubling per code
// [R2] force bit starts conversion, sinks on, backlight off
// [R3] force bit self-clears when results valid
// [R4] force write ignored while backlight enabled
// [R5] bit 3 reads dark comparator output
// [R6] bit 2 reads office comparator output
// [R7] bit 1 enables dark comparator
// [R8] bit 0 enables office comparator
// [R9] dark result wins over office result
// [R10] input below threshold selects office level
// [R11] threshold code step is 4.3 uA
// [R12] host keeps threshold code at most 250
// [R13] host keeps threshold plus hysteresis at most 250
// [R14] input above threshold plus hysteresis selects daylight
// [R15] input below dark threshold selects dark level
// [R16] disabled comparator reads zero, not used
`timescale 1ns/1ns
module alc_comparator_cfg
    import alc_pkg::*;
#(
    parameter int BASE_CYC = ALC_BASE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire alc_req_t req,
    input wire logic req_valid,
    output logic [7:0] rdata,
    // system state
    input wire logic backlight_on,
    input wire logic sinks_active,
    input wire logic [7:0] dark_level_threshold,
    // sensor
    input wire logic [7:0] second_light_sensor_input,
    // results
    output alc_level_t level,
    output logic conv_done
);
    logic [2:0] sensor_filter_period_sel;
    logic forced_conversion_request;
    logic dark_comparator_result;
    logic office_comparator_result;
    logic dark_comparator_enable;
    logic office_comparator_enable;
    logic [7:0] office_level_threshold;
    logic [7:0] office_level_hysteresis;
    logic force_pending_reg;
    logic tick;
    logic sample;
    logic force_set;
    logic [8:0] trip_up;
    logic [7:0] cfg_rd;

    function automatic logic hit(input alc_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    alc_filter #(.BASE_CYC(BASE_CYC)) u_filter (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .period_sel(sensor_filter_period_sel),
        .restart(force_set),
        .tick(tick)
    );

    always_comb begin
        force_set = req_valid && hit(req, ALC_CFG_ADDR) && req.wdata[ALC_FORCE_BIT]
            && !backlight_on && sinks_active; // [R2] [R4]
        // a forced conversion lands one cycle after the request is taken
        sample = tick || force_pending_reg;
        // threshold codes and input share the 4.3 uA scale, so raw compare [R11]
        trip_up = {1'b0, office_level_threshold} + {1'b0, office_level_hysteresis};
        cfg_rd = {sensor_filter_period_sel, forced_conversion_request,
            dark_comparator_result, office_comparator_result,
            dark_comparator_enable, office_comparator_enable};
    end

    // writable fields
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sensor_filter_period_sel <= ALC_CFG_RST[7:5];
            dark_comparator_enable <= ALC_CFG_RST[ALC_DARK_EN_BIT];
            office_comparator_enable <= ALC_CFG_RST[ALC_OFF_EN_BIT];
            office_level_threshold <= ALC_THR_RST;
            office_level_hysteresis <= ALC_HYS_RST;
        end else if (req_valid) begin
            if (hit(req, ALC_CFG_ADDR)) begin
                sensor_filter_period_sel <= req.wdata[7:ALC_FILT_LSB]; // [R1]
                dark_comparator_enable <= req.wdata[ALC_DARK_EN_BIT]; // [R7]
                office_comparator_enable <= req.wdata[ALC_OFF_EN_BIT]; // [R8]
            end else if (hit(req, ALC_THR_ADDR)) begin
                office_level_threshold <= req.wdata;
            end else if (hit(req, ALC_HYS_ADDR)) begin
                office_level_hysteresis <= req.wdata;
            end
        end
    end

    // forced conversion request
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            forced_conversion_request <= 1'b0;
            force_pending_reg <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            force_pending_reg <= force_set;
            conv_done <= force_pending_reg;
            if (force_set) begin
                forced_conversion_request <= 1'b1; // [R2]
            end else if (force_pending_reg) begin
                forced_conversion_request <= 1'b0; // [R3]
            end
        end
    end

    // dark comparator, and office comparator with hysteresis
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dark_comparator_result <= 1'b0;
            office_comparator_result <= 1'b0;
        end else begin
            if (!dark_comparator_enable) begin
                dark_comparator_result <= 1'b0; // [R16]
            end else if (sample) begin
                dark_comparator_result <= second_light_sensor_input < dark_level_threshold; // [R15]
            end
            if (!office_comparator_enable) begin
                office_comparator_result <= 1'b0; // [R16]
            end else if (sample) begin
                if (second_light_sensor_input < office_level_threshold) begin
                    office_comparator_result <= 1'b1; // [R10]
                end else if ({1'b0, second_light_sensor_input} > trip_up) begin
                    office_comparator_result <= 1'b0; // [R14]
                end
            end
        end
    end

    // level choice
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            level <= ALC_LVL_DAYLIGHT;
        end else if (dark_comparator_result) begin
            level <= ALC_LVL_DARK; // [R9]
        end else if (office_comparator_result) begin
            level <= ALC_LVL_OFFICE; // [R10]
        end else begin
            level <= ALC_LVL_DAYLIGHT; // [R14]
        end
    end

    // read port; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (req.addr == ALC_CFG_ADDR) begin
            rdata <= cfg_rd; // [R5] [R6]
        end else if (req.addr == ALC_THR_ADDR) begin
            rdata <= office_level_threshold;
        end else if (req.addr == ALC_HYS_ADDR) begin
            rdata <= office_level_hysteresis;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

// >>> pkg/alc_pkg.sv
// Purpose: shared constants and types for the second-sensor comparator block
// Assumes: 8-bit register port, 250 MHz system clock
// Notes: sensor input is an 8-bit current code, one step per threshold lsb
package alc_pkg;
    localparam logic [7:0] ALC_CFG_ADDR = 8'h1c;
    localparam logic [7:0] ALC_THR_ADDR = 8'h1d;
    localparam logic [7:0] ALC_HYS_ADDR = 8'h1e;
    localparam int ALC_FILT_LSB = 5;
    localparam int ALC_FORCE_BIT = 4;
    localparam int ALC_DARK_OUT_BIT = 3;
    localparam int ALC_OFF_OUT_BIT = 2;
    localparam int ALC_DARK_EN_BIT = 1;
    localparam int ALC_OFF_EN_BIT = 0;
    localparam logic [7:0] ALC_CFG_RST = 8'h00;
    localparam logic [7:0] ALC_THR_RST = 8'h00;
    localparam logic [7:0] ALC_HYS_RST = 8'h00;
    localparam logic [7:0] ALC_CODE_MAX = 8'hfa;
    // one threshold code step is 4.3 uA, expressed in nA
    localparam int ALC_STEP_NA = 4300;
    localparam int ALC_CLK_MHZ = 250;
    localparam int ALC_BASE_MS = 80;
    localparam int ALC_BASE_CYC = ALC_BASE_MS * ALC_CLK_MHZ * 1000;
    typedef enum logic [1:0] {
        ALC_LVL_DAYLIGHT,
        ALC_LVL_OFFICE,
        ALC_LVL_DARK
    } alc_level_t;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } alc_req_t;
endpackage

// >>> verilog/alc_filter.sv
// Purpose: sensor filter period timer, one tick per selected period
// Assumes: base count is one 80 ms period in system clocks
// Notes: restart realigns the period, used when a forced conversion begins
`timescale 1ns/1ns
module alc_filter
    import alc_pkg::*;
#(
    parameter int BASE_CYC = ALC_BASE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control
    input wire logic [2:0] period_sel,
    input wire logic restart,
    // tick
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] limit;
    always_comb begin
        limit = (32'(BASE_CYC) << period_sel) - 32'h1; // [R1]
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else if (restart) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_reg >= limit) begin
            cnt_reg <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// >>> sim/alc_sensor_model.sv
// Purpose: phototransistor current as an 8-bit code
// Assumes: code follows the requested light one clock later
// Notes: no noise, so a tick resample sees the same value
`timescale 1ns/1ns
module alc_sensor_model (
    input wire logic clk_sys,
    input wire logic [7:0] target,
    output logic [7:0] code
);
    always_ff @(posedge clk_sys) begin
        code <= target;
    end
endmodule

// >>> sim/alc_cfg_properties.sv
// Purpose: port checks on the comparator block
// Assumes: one clock, rstn low resets
// Notes: status and level judged the cycle after conv_done
`timescale 1ns/1ns
module alc_cfg_properties
    import alc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire alc_req_t req,
    input wire logic req_valid,
    input wire logic [7:0] rdata,
    input wire logic backlight_on,
    input wire logic sinks_active,
    input wire logic [7:0] dark_level_threshold,
    input wire logic [7:0] second_light_sensor_input,
    input wire alc_level_t level,
    input wire logic conv_done
);
    logic seen_reg;
    logic frc;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    assign frc = req_valid && req.wr && req.addr == ALC_CFG_ADDR && req.wdata[4];
    // rdata lags the address by a cycle, so the flag does too
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) seen_reg <= 1'b0;
        else seen_reg <= conv_done && req.addr == ALC_CFG_ADDR;
    end
    AST_DONE_ONE: assert property (conv_done |=> !conv_done)
        else $error("done too long");
    AST_FORCE_GO: assert property (frc && !backlight_on && sinks_active |-> ##2 conv_done)
        else $error("no conversion");
    AST_FORCE_IGN: assert property (frc && (backlight_on || !sinks_active) |-> ##2 !conv_done)
        else $error("force not ignored");
    AST_CLR: assert property (seen_reg |-> !rdata[4])
        else $error("force bit stuck");
    AST_DARK_WINS: assert property (seen_reg && rdata[3] |-> level == ALC_LVL_DARK)
        else $error("dark not chosen");
    AST_OFFICE: assert property (seen_reg && rdata[3:2] == 2'b01 |-> level == ALC_LVL_OFFICE)
        else $error("office not chosen");
    AST_DARK_CMP: assert property (seen_reg |-> rdata[3] == (rdata[1] &&
        $past(second_light_sensor_input) < $past(dark_level_threshold))) else $error("dark bad");
    AST_OFF_MASK: assert property (seen_reg && !rdata[0] |-> !rdata[2])
        else $error("office not masked");
endmodule
bind alc_comparator_cfg alc_cfg_properties alc_cfg_properties_i(.clk_sys(clk_sys),.rstn(rstn),
    .req(req),.req_valid(req_valid),.rdata(rdata),.backlight_on(backlight_on),
    .sinks_active(sinks_active),.dark_level_threshold(dark_level_threshold),
    .second_light_sensor_input(second_light_sensor_input),.level(level),.conv_done(conv_done));

// >>> sim/tb_alc_comparator_cfg.sv
// Purpose: random forced conversions against a bench model
// Assumes: short filter base, period 7 keeps ticks away
// Notes: refused forces leave inputs alone
`timescale 1ns/1ns
module tb_alc_comparator_cfg;
    import alc_pkg::*;
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; \
$display("wrong value %s exp %h got %h", n, e, a); end end
    logic clk_sys = 0, rstn = 0, req_valid = 0, backlight_on = 0, sinks_active = 1, conv_done;
    logic [7:0] rdata, sens, dark = 0, tgt = 0, cfg = 0;
    logic [31:0] rs = 32'h00c7;
    alc_req_t req = '0;
    alc_level_t level;
    int errors = 0, compares = 0, thr, hys, ost = 0, dst = 0, ok;
    always #2 clk_sys = ~clk_sys;
    alc_sensor_model alc_sensor_model_i(.clk_sys(clk_sys), .target(tgt), .code(sens));
    alc_comparator_cfg #(.BASE_CYC(16)) alc_comparator_cfg_i(.clk_sys(clk_sys), .rstn(rstn),
        .req(req), .req_valid(req_valid), .rdata(rdata), .backlight_on(backlight_on),
        .sinks_active(sinks_active), .dark_level_threshold(dark),
        .second_light_sensor_input(sens), .level(level), .conv_done(conv_done));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = {1'b1, a, d};
        req_valid = 1;
        @(negedge clk_sys);
        req_valid = 0;
        req = {1'b0, ALC_CFG_ADDR, d};
    endtask
    task automatic test_done;
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        rstn = 1;
        for (int a = 0; a < 3; a++) begin
            req.addr = ALC_CFG_ADDR + 8'(a);
            repeat (2) @(negedge clk_sys);
            `CHK("reset", 8'h00, rdata)
        end
        for (int i = 0; i < 60; i++) begin
            rs = xs(rs);
            ok = rs[31:30] != 0;
            backlight_on = !ok && rs[1];
            sinks_active = ok || (rs[1] && rs[0]);
            if (ok) begin
                tgt = rs[29:22] >> 1;
                dark = rs[7:0] >> 1;
                thr = rs[20:14];
                hys = rs[13:8] >> 1;
                wr(ALC_THR_ADDR, 8'(thr));
                wr(ALC_HYS_ADDR, 8'(hys));
                cfg = {6'b111000, rs[3:2]};
                ost = !cfg[0] ? 0 : tgt < thr ? 1 : tgt > thr + hys ? 0 : ost;
                dst = cfg[1] && tgt < dark;
            end
            wr(ALC_CFG_ADDR, cfg | 8'h10);
            // conv_done stands only in the second cycle after the force is taken
            @(negedge clk_sys);
            `CHK("done", ok[0], conv_done)
            @(negedge clk_sys);
            `CHK("cfg", cfg | 8'(dst << 3) | 8'(ost << 2), rdata)
            `CHK("level", dst ? ALC_LVL_DARK : ost ? ALC_LVL_OFFICE : ALC_LVL_DAYLIGHT, level)
            req.addr = ALC_THR_ADDR;
            repeat (2) @(negedge clk_sys);
            `CHK("thr", 8'(thr), rdata)
        end
        test_done;
    end
    initial begin
        #20000;
        errors++;
        test_done;
    end
endmodule
